// ===== bench/emu_model.sv
`timescale 1ns/1ps
module emu_model (
    input  wire logic       mclk,
    output logic            dbgResetReq,
    output logic [1:0]      breakReq,
    output logic [1:0]      stepReq,
    output logic [1:0]      resumeReq
);
    initial begin
        dbgResetReq = 1'b0;
        breakReq = 2'h0;
        stepReq = 2'h0;
        resumeReq = 2'h0;
    end
    // One command per call, one cycle wide; commands never overlap
    task automatic send(input int op, input logic [1:0] cpus);
        @(posedge mclk);
        #1;
        case (op)
            0: dbgResetReq = 1'b1;
            1: breakReq = cpus;
            2: stepReq = cpus;
            default: resumeReq = cpus;
        endcase
        @(posedge mclk);
        #1;
        dbgResetReq = 1'b0;
        breakReq = 2'h0;
        stepReq = 2'h0;
        resumeReq = 2'h0;
    endtask
endmodule // emu_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dbg_run_pkg::*;
    logic mclk, reset_n, userResetReq, dbgResetMaskEn, dbgResetReq, sysReset, resetPending;
    logic [1:0] breakReq, stepReq, resumeReq, stepRetired, haltExec, handlerBreakHit;
    logic [1:0] inBreak, inHalt, dbgMasked;
    logic [5:0] irqIn, irqOut, seenIrq;
    logic       seenRst;
    int         failures, cmp_count, seed;
    int         st [2];
    emu_model emu_model_inst (.mclk(mclk), .dbgResetReq(dbgResetReq), .breakReq(breakReq),
        .stepReq(stepReq), .resumeReq(resumeReq));
    debug_run_control debug_run_control_inst (.mclk(mclk), .reset_n(reset_n),
        .userResetReq(userResetReq), .dbgResetReq(dbgResetReq),
        .dbgResetMaskEn(dbgResetMaskEn), .breakReq(breakReq), .stepReq(stepReq),
        .resumeReq(resumeReq), .stepRetired(stepRetired), .haltExec(haltExec),
        .handlerBreakHit(handlerBreakHit), .irqIn(irqIn), .sysReset(sysReset),
        .resetPending(resetPending), .irqOut(irqOut), .inBreak(inBreak), .inHalt(inHalt),
        .dbgMasked(dbgMasked));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Model state per CPU: 0 real time, 1 stepping, 2 break, 3 halt
    task automatic chk_state;
        logic [5:0] e;
        for (int c = 0; c < NUM_CPU; c++) begin
            e[c] = (st[c] == 2);
            e[c+2] = (st[c] == 3);
            e[c+4] = (st[c] == 1 || st[c] == 2);
        end
        check({2'h0, dbgMasked, inHalt, inBreak}, {2'h0, e});
    endtask
    task automatic user_reset;
        userResetReq = 1'b1;
        tick(1);
        userResetReq = 1'b0;
    endtask
    // Bounded window: collects what a released mask lets through
    task automatic collect;
        seenIrq = 6'h0;
        seenRst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            seenIrq = seenIrq | irqOut;
            seenRst = seenRst | sysReset;
            tick(1);
        end
    endtask
    task automatic print_verdict;
        $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        seed = 98;
        st = '{0, 0};
        {reset_n, userResetReq, dbgResetMaskEn, stepRetired, haltExec} = 7'h0;
        handlerBreakHit = 2'h0;
        irqIn = 6'h0;
        tick(3);
        reset_n = 1'b1;
        // Short stand-in for the start-up wait; the full one would overrun the run
        tick(2);
        chk_state();
        check(8'({sysReset, resetPending}), 8'h0);
        $display("test reset done");
        repeat (4) begin
            irqIn = 6'($random(seed));
            #1 check(8'(irqOut), 8'(irqIn));
            tick(1);
        end
        user_reset();
        check(8'({sysReset, resetPending}), 8'h2);
        dbgResetMaskEn = 1'b1;
        user_reset();
        check(8'({sysReset, resetPending}), 8'h1);
        dbgResetMaskEn = 1'b0;
        collect();
        check(8'(seenRst), 8'h1);
        $display("test realtime done");
        emu_model_inst.send(1, 2'b01);
        st[0] = 2;
        chk_state();
        irqIn = 6'($random(seed)) | 6'h07;
        #1 check(8'(irqOut), {2'h0, irqIn[5:3], 3'h0});
        tick(1);
        irqIn = 6'h0;
        user_reset();
        tick(1);
        check(8'({sysReset, resetPending}), 8'h1);
        emu_model_inst.send(3, 2'b01);
        st[0] = 0;
        collect();
        check(8'(seenIrq), 8'h07);
        check(8'(seenRst), 8'h1);
        $display("test pending done");
        dbgResetMaskEn = 1'b1;
        emu_model_inst.send(0, 2'b00);
        check(8'(sysReset), 8'h1);
        tick(3);
        st = '{2, 2};
        chk_state();
        $display("test debugger reset done");
        emu_model_inst.send(2, 2'b01);
        st[0] = 1;
        chk_state();
        haltExec = 2'b01;
        tick(1);
        {haltExec, stepRetired} = 4'h0;
        tick(2);
        st[0] = 2;
        chk_state();
        emu_model_inst.send(3, 2'b11);
        dbgResetMaskEn = 1'b0;
        haltExec = 2'b10;
        tick(1);
        haltExec = 2'h0;
        tick(2);
        st = '{0, 3};
        chk_state();
        emu_model_inst.send(1, 2'b10);
        st[1] = 2;
        chk_state();
        irqIn = 6'h01;
        handlerBreakHit = 2'b01;
        tick(1);
        {handlerBreakHit, irqIn} = 8'h0;
        tick(2);
        st[0] = 2;
        chk_state();
        $display("test halt and step done");
        print_verdict();
    end
endmodule // tb_top

// ===== design/cpu_run_ctrl.sv
`timescale 1ns/1ps
module cpu_run_ctrl
    import dbg_run_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       sysResetDone,
    input  wire logic       breakReq,
    input  wire logic       stepReq,
    input  wire logic       resumeReq,
    input  wire logic       stepRetired,
    input  wire logic       haltExec,
    input  wire logic       handlerBreakHit,
    input  wire logic [2:0] irqIn,
    output logic [2:0]      irqOut,
    output logic [2:0]      irqPending,
    output logic            dbgMask,
    output logic            inBreak,
    output logic            inHalt,
    output run_state_t      runState
);
    run_state_t next_runState;
    logic [2:0] next_irqPending;
    wire  masked  = (runState == RUN_BREAK) || (runState == RUN_STEP);

    always_comb begin
        next_runState = runState;
        case (runState)
            RUN_REALTIME: begin
                if (breakReq || handlerBreakHit) begin
                    next_runState = RUN_BREAK; // RULE_09
                end else if (haltExec) begin
                    next_runState = RUN_HALT;
                end
            end
            RUN_HALT: begin
                if (breakReq) begin
                    next_runState = RUN_BREAK; // RULE_10
                end
            end
            RUN_STEP: begin
                // Halt retired while stepping lands in break, never in halt
                if (stepRetired || haltExec || breakReq) begin
                    next_runState = RUN_BREAK; // RULE_11
                end
            end
            RUN_BREAK: begin
                if (stepReq) begin
                    next_runState = RUN_STEP;
                end else if (resumeReq) begin
                    next_runState = RUN_REALTIME;
                end
            end
            default: next_runState = RUN_BREAK;
        endcase
        if (sysResetDone) begin
            next_runState = RUN_BREAK; // RULE_04
        end
    end

    // Pending bits: the release clear wins over new arrivals
    assign next_irqPending = masked ? (irqPending | irqIn) : irqIn & 3'h0; // RULE_08
    // Pending classes are presented the first unmasked cycle, then source drives
    assign irqOut  = masked ? 3'h0 : (irqIn | irqPending); // RULE_06 RULE_07 RULE_17
    assign dbgMask = masked;
    assign inBreak = (runState == RUN_BREAK);
    assign inHalt  = (runState == RUN_HALT);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            runState   <= RUN_STATE_INIT;
            irqPending <= IRQ_PENDING_INIT;
        end else begin
            runState   <= next_runState;
            irqPending <= next_irqPending;
        end
    end

    a_halt_from_step: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_11
        (runState == RUN_STEP && haltExec && !sysResetDone) |=> runState == RUN_BREAK)
        else $error("halt during step did not land in break");
    a_break_wakes: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_10
        (runState == RUN_HALT && breakReq && !sysResetDone) |=> inBreak && !inHalt)
        else $error("break did not release halt");
    a_irq_gated: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_06
        masked |-> irqOut == 3'h0)
        else $error("interrupt leaked while masked");
    a_irq_kept: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_08
        (masked && irqIn != 3'h0) |=> ((irqPending & $past(irqIn)) == $past(irqIn)))
        else $error("masked interrupt not held");
    a_irq_replay: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_17
        ($past(masked) && !masked) |-> ((irqOut & $past(irqPending | irqIn)) ==
            $past(irqPending | irqIn)))
        else $error("pending interrupt not delivered on release");
    a_irq_pass: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_07
        (runState == RUN_REALTIME) |-> ((irqOut & irqIn) == irqIn))
        else $error("interrupt blocked in real time");
    a_handler_brk: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_09
        (runState == RUN_REALTIME && handlerBreakHit) |=> inBreak)
        else $error("handler breakpoint missed");
    c_step_halt: cover property (@(posedge mclk) disable iff (!reset_n)
        runState == RUN_STEP && haltExec);
endmodule // cpu_run_ctrl

// ===== design/dbg_run_pkg.sv
package dbg_run_pkg;
    localparam int NUM_CPU      = 2;
    localparam int NUM_IRQ_KIND = 3;
    // Interrupt class bit positions
    localparam int IRQ_MASKABLE = 0;
    localparam int IRQ_FAST     = 1;
    localparam int IRQ_FPU      = 2;
    // Per-CPU run state
    typedef enum logic [1:0] {
        RUN_REALTIME = 2'b00,
        RUN_STEP     = 2'b01,
        RUN_BREAK    = 2'b11,
        RUN_HALT     = 2'b10
    } run_state_t;
    localparam logic       RESET_PENDING_INIT = 1'b0;
    localparam logic [2:0] IRQ_PENDING_INIT   = 3'h0;
    localparam run_state_t RUN_STATE_INIT     = RUN_REALTIME;
    // Start-up wait the user program should respect after reset release
    localparam int STARTUP_WAIT_MS    = 10;
    localparam int CLOCK_MHZ          = 125;
    localparam int STARTUP_WAIT_CYCLES = STARTUP_WAIT_MS * 1000 * CLOCK_MHZ;
endpackage

// ===== design/debug_run_control.sv
`timescale 1ns/1ps
// Operation
// RULE_01 - Break or stepping masks user resets regardless of debugger mask setting.
// RULE_02 - Real-time run with mask clear applies user resets immediately.
// RULE_03 - Debugger reset is always accepted, masked or not.
// RULE_04 - After debugger reset completes every CPU enters break.
// RULE_05 - Resets arriving while masked are held pending and applied after unmask.
// RULE_06 - Break or stepping masks interrupts to that CPU.
// RULE_07 - Real-time run delivers interrupts as the system configures them.
// RULE_08 - Masked maskable, fast and floating-point interrupts stay pending until unmask.
// RULE_09 - Breakpoint on handler start stops the CPU there on interrupt.
// RULE_10 - Entering break takes a CPU out of halt.
// RULE_11 - Halt during instruction stepping stops in break at next instruction.
// RULE_12 - Target drives pin reset only while program runs.
// RULE_13 - Target must not hold reset while emulator link is prepared.
// RULE_14 - Device runs stored program from reset vector before link exists.
// RULE_15 - User program should wait 10 ms after reset release.
// RULE_16 - Program internal resets should wait 10 ms after initial release.
// RULE_17 - Pending reset or interrupt applies first cycle after mask release.
module debug_run_control
    import dbg_run_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire logic                     userResetReq,
    input  wire logic                     dbgResetReq,
    input  wire logic                     dbgResetMaskEn,
    input  wire logic [NUM_CPU-1:0]       breakReq,
    input  wire logic [NUM_CPU-1:0]       stepReq,
    input  wire logic [NUM_CPU-1:0]       resumeReq,
    input  wire logic [NUM_CPU-1:0]       stepRetired,
    input  wire logic [NUM_CPU-1:0]       haltExec,
    input  wire logic [NUM_CPU-1:0]       handlerBreakHit,
    input  wire logic [NUM_CPU*3-1:0]     irqIn,
    output logic                          sysReset,
    output logic                          resetPending,
    output logic [NUM_CPU*3-1:0]          irqOut,
    output logic [NUM_CPU-1:0]            inBreak,
    output logic [NUM_CPU-1:0]            inHalt,
    output logic [NUM_CPU-1:0]            dbgMasked
);
    logic [NUM_CPU-1:0] cpuMask;
    logic               dbgResetDone;
    logic               next_resetPending;
    logic               next_sysReset;
    logic               dbgResetSeen;

    wire anyMasked = |cpuMask;
    // Debugger mask bit only matters while no CPU is in break or step; break/step always mask
    wire userMasked = anyMasked || dbgResetMaskEn; // RULE_01 RULE_02
    wire userFire   = !userMasked && (userResetReq || resetPending); // RULE_02 RULE_17

    // Debugger reset bypasses every mask
    assign next_sysReset = dbgResetReq || userFire; // RULE_03
    // Held reset survives until the mask drops; the clear wins over a new one
    assign next_resetPending = (userMasked && (userResetReq || resetPending)); // RULE_05

    // Out of reset the CPUs run the stored image at once, no link wait
    always_ff @(posedge mclk or negedge reset_n) begin // RULE_14
        if (!reset_n) begin
            sysReset     <= 1'b0;
            resetPending <= RESET_PENDING_INIT;
            dbgResetDone <= 1'b0;
        end else begin
            sysReset     <= next_sysReset;
            resetPending <= next_resetPending;
            dbgResetDone <= dbgResetReq && !next_sysReset ? 1'b0 : (sysReset && !next_sysReset &&
                            dbgResetSeen);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dbgResetSeen <= 1'b0;
        end else if (dbgResetReq) begin
            dbgResetSeen <= 1'b1;
        end else if (!sysReset) begin
            dbgResetSeen <= 1'b0;
        end
    end

    genvar c;
    generate
        for (c = 0; c < NUM_CPU; c++) begin : g_cpu
            cpu_run_ctrl u_cpu (
                .mclk            (mclk),
                .reset_n         (reset_n),
                .sysResetDone    (dbgResetDone), // RULE_04
                .breakReq        (breakReq[c]),
                .stepReq         (stepReq[c]),
                .resumeReq       (resumeReq[c]),
                .stepRetired     (stepRetired[c]),
                .haltExec        (haltExec[c]),
                .handlerBreakHit (handlerBreakHit[c]),
                .irqIn           (irqIn[c*3 +: 3]),
                .irqOut          (irqOut[c*3 +: 3]),
                .irqPending      (),
                .dbgMask         (cpuMask[c]),
                .inBreak         (inBreak[c]),
                .inHalt          (inHalt[c]),
                .runState        ()
            );
        end
    endgenerate

    assign dbgMasked = cpuMask;

    a_mask_user_rst: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_01
        (anyMasked && !dbgResetReq) |=> !sysReset)
        else $error("user reset passed during break or step");
    a_user_rst_now: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_02
        (!anyMasked && !dbgResetMaskEn && userResetReq) |=> sysReset)
        else $error("real-time user reset not applied");
    a_dbg_rst_wins: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_03
        dbgResetReq |=> sysReset)
        else $error("debugger reset refused");
    a_rst_held: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_05
        (userMasked && userResetReq) |=> resetPending)
        else $error("masked reset not recorded");
    a_rst_replay: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_17
        (resetPending && !userMasked) |=> (sysReset && !resetPending))
        else $error("pending reset not applied on release");
    a_dbg_rst_brk: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_04
        (dbgResetReq ##1 (!dbgResetReq && !userFire)) |=> ##1 (&inBreak))
        else $error("CPUs not in break after debugger reset");

    // Per-CPU checks of mask, break and halt, seen at the top-level pins
    generate
        for (c = 0; c < NUM_CPU; c++) begin : g_chk
            a_cpu_irq_mask: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_06
                dbgMasked[c] |-> (irqOut[c*3 +: 3] == 3'h0))
                else $error("interrupt pin active while CPU masked");
            a_cpu_brk_mask: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_01
                inBreak[c] |-> dbgMasked[c])
                else $error("break without mask");
            a_cpu_brk_halt: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_10
                !(inBreak[c] && inHalt[c]))
                else $error("CPU in break and halt together");
            a_cpu_rt_irq: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_07
                !dbgMasked[c] |-> ((irqOut[c*3 +: 3] & irqIn[c*3 +: 3]) == irqIn[c*3 +: 3]))
                else $error("interrupt blocked while unmasked");
            a_cpu_brk_req: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_10
                (breakReq[c] && !stepReq[c] && !resumeReq[c]) |=> inBreak[c])
                else $error("break request not taken");
        end
    endgenerate
    c_dbg_rst: cover property (@(posedge mclk) disable iff (!reset_n) dbgResetReq ##2 (&inBreak));
    c_pend_rst: cover property (@(posedge mclk) disable iff (!reset_n)
        resetPending ##1 !resetPending && sysReset);
    c_brk_any: cover property (@(posedge mclk) disable iff (!reset_n) |inBreak);
endmodule // debug_run_control
